// file: output_driver_protection_ctrl.sv
// protection, diagnosis and switch-off control of the output drivers
`timescale 1ns/1ps

module output_driver_protection_ctrl (
    input  wire logic                          i_clk,
    input  wire logic                          i_srst,
    input  wire logic                          i_ce,
    input  wire prot_pkg::bus_req_t            i_bus,
    output logic [prot_pkg::DW-1:0]            o_rdata,
    input  wire prot_pkg::fault_t              i_fault_pin,
    input  wire logic                          i_standby,
    input  wire logic [prot_pkg::NDRV-1:0]     i_wake_evt,
    input  wire logic                          i_v1_restart_fail,
    input  wire logic                          i_wd_fail,
    input  wire logic                          i_wd_ok,
    output logic [prot_pkg::NDRV-1:0]          o_drv_on,
    output logic [1:0]                         o_therm_state
);

    // sticky flag update, a new event beats a clear
    function automatic logic [prot_pkg::NDRV-1:0] sticky(
        input logic [prot_pkg::NDRV-1:0] old_v,
        input logic [prot_pkg::NDRV-1:0] set_v,
        input logic [prot_pkg::NDRV-1:0] clr_v
    );
        sticky = (old_v & ~clr_v) | set_v;
    endfunction : sticky

    // saturating counter step
    function automatic logic [prot_pkg::CNT_W-1:0] sat_inc(
        input logic [prot_pkg::CNT_W-1:0] v
    );
        if (v == prot_pkg::CNT_MAX) begin
            sat_inc = v;
        end else begin
            sat_inc = v + 4'h1;
        end
    endfunction : sat_inc

    prot_pkg::fault_t                 meta_r;
    prot_pkg::fault_t                 flt_r;
    logic [prot_pkg::NDRV-1:0]        ctrl_out_r;
    prot_pkg::ctrl4_t                 ctrl4_r;
    prot_pkg::therm_t                 therm_r;
    prot_pkg::therm_t                 saved_r;
    prot_pkg::therm_t                 therm_live;
    logic                             stby_d_r;
    logic                             ov_r;
    logic                             uv_r;
    logic [prot_pkg::NDRV-1:0]        ovld_r;
    logic [prot_pkg::NDRV-1:0]        open_r;
    logic [prot_pkg::NDRV-1:0]        wake_r;
    logic                             chip_rst_r;
    logic                             spi_err_r;
    logic [prot_pkg::CNT_W-1:0]       v1_cnt_r;
    logic [prot_pkg::CNT_W-1:0]       wd_cnt_r;

    logic                             frame_ok;
    logic                             wr_ok;
    logic                             rd_ok;
    logic [prot_pkg::NDRV-1:0]        wr_bits;
    logic                             therm_off;
    logic                             sup_fault;
    logic                             sup_block;
    logic [prot_pkg::NDRV-1:0]        therm_exempt;
    logic [prot_pkg::NDRV-1:0]        fs_keep;
    logic [prot_pkg::NDRV-1:0]        rec_mask;
    logic [prot_pkg::NDRV-1:0]        sup_off;
    logic [prot_pkg::NDRV-1:0]        ovld_set;
    logic [prot_pkg::NDRV-1:0]        hard_off;
    logic [prot_pkg::NDRV-1:0]        ovld_view;
    logic [prot_pkg::DW-1:0]          rd_val;

    // two-flop capture of the analog comparator levels
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            meta_r <= '0;
            flt_r  <= '0;
        end else if (i_ce) begin
            meta_r <= i_fault_pin;
            flt_r  <= meta_r;
        end
    end

    // frame length gate on every access
    always_comb begin
        frame_ok = (i_bus.bits == prot_pkg::FRAME_BITS);
        wr_ok    = i_bus.wr & frame_ok;
        rd_ok    = i_bus.rd & frame_ok;
        wr_bits  = i_bus.wdata[prot_pkg::NDRV-1:0];
    end

    // protection terms
    always_comb begin
        therm_exempt = '0;
        fs_keep      = '0;
        rec_mask     = '0;
        therm_exempt[prot_pkg::THIRD_IDX] = ctrl4_r.third_highside_output_fso;
        fs_keep[prot_pkg::THIRD_IDX]      = ~ctrl4_r.third_highside_output_fso;
        rec_mask[prot_pkg::STRONG_IDX]    = ctrl4_r.auto_rec;
        therm_off = (therm_r == prot_pkg::TH_SD1)
                  | (therm_r == prot_pkg::TH_SD2);
        sup_fault = flt_r.ov | flt_r.uv;
        if (ctrl4_r.vlockout) begin
            sup_block = sup_fault | ov_r | uv_r;
        end else begin
            sup_block = sup_fault;
        end
        sup_off = {{2{sup_block & ctrl4_r.relay_sf_en}},
                   {prot_pkg::NHS{sup_block}}};
        ovld_set = (flt_r.oc | {prot_pkg::NDRV{therm_r == prot_pkg::TH_SD1}})
                 & ~therm_exempt & ~rec_mask;
        hard_off = ovld_r
                 | ({prot_pkg::NDRV{therm_off}} & ~therm_exempt)
                 | sup_off
                 | flt_r.oc
                 | ({prot_pkg::NDRV{flt_r.failsafe}} & ~fs_keep);
    end

    // thermal level from the comparators
    always_comb begin
        if (flt_r.thermal_shutdown_level_two) begin
            therm_live = prot_pkg::TH_SD2;
        end else if (flt_r.thermal_shutdown_level_one) begin
            therm_live = prot_pkg::TH_SD1;
        end else if (flt_r.tw) begin
            therm_live = prot_pkg::TH_WARN;
        end else begin
            therm_live = prot_pkg::TH_NORMAL;
        end
    end

    // thermal state with standby save and restore, a saved level two comes back as level one
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            therm_r  <= prot_pkg::TH_NORMAL;
            saved_r  <= prot_pkg::TH_NORMAL;
            stby_d_r <= 1'b0;
        end else if (i_ce) begin
            stby_d_r <= i_standby;
            if (i_standby & ~stby_d_r) begin
                saved_r <= therm_r;
            end
            if (i_standby) begin
                therm_r <= therm_r;
            end else if (stby_d_r) begin
                unique case (saved_r)
                    prot_pkg::TH_SD2: therm_r <= prot_pkg::TH_SD1;
                    prot_pkg::TH_SD1: therm_r <= prot_pkg::TH_SD1;
                    prot_pkg::TH_WARN: therm_r <= prot_pkg::TH_WARN;
                    prot_pkg::TH_NORMAL: therm_r <= prot_pkg::TH_NORMAL;
                endcase
            end else begin
                therm_r <= therm_live;
            end
        end
    end

    // driver enable bits, fail-safe returns them to default, the THIRD_IDX bit only when third_highside_output_fso is set
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl_out_r <= prot_pkg::CTRL_OUT_RST;
        end else if (i_ce) begin
            if (flt_r.failsafe) begin
                ctrl_out_r <= (ctrl_out_r & fs_keep)
                            | (prot_pkg::CTRL_OUT_RST & ~fs_keep);
            end else if (wr_ok && i_bus.addr == prot_pkg::OFF_CTRL_OUT) begin
                ctrl_out_r <= wr_bits;
            end
        end
    end

    // option bits
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ctrl4_r <= prot_pkg::CTRL4_RST;
        end else if (i_ce) begin
            if (wr_ok && i_bus.addr == prot_pkg::OFF_CTRL4) begin
                ctrl4_r <= i_bus.wdata[3:0];
            end
        end
    end

    // supply fault flags, read clears, auto clear without lockout
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ov_r <= 1'b0;
            uv_r <= 1'b0;
        end else if (i_ce) begin
            if (flt_r.ov) begin
                ov_r <= 1'b1;
            end else if ((rd_ok && i_bus.addr == prot_pkg::OFF_SUPPLY)
                         || !ctrl4_r.vlockout) begin
                ov_r <= 1'b0;
            end
            if (flt_r.uv) begin
                uv_r <= 1'b1;
            end else if ((rd_ok && i_bus.addr == prot_pkg::OFF_SUPPLY)
                         || !ctrl4_r.vlockout) begin
                uv_r <= 1'b0;
            end
        end
    end

    // overload and open-load status, write one to clear
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            ovld_r <= '0;
            open_r <= '0;
        end else if (i_ce) begin
            ovld_r <= sticky(ovld_r, ovld_set,
                (wr_ok && i_bus.addr == prot_pkg::OFF_OVLD) ? wr_bits : '0);
            open_r <= sticky(open_r, {2'b00, flt_r.ol},
                (wr_ok && i_bus.addr == prot_pkg::OFF_OPEN) ? wr_bits : '0);
        end
    end

    // wake-up source record
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            wake_r <= '0;
        end else if (i_ce) begin
            wake_r <= sticky(wake_r, i_wake_evt,
                (wr_ok && i_bus.addr == prot_pkg::OFF_WAKE) ? wr_bits : '0);
        end
    end

    // chip reset and serial error flags
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            chip_rst_r <= 1'b1;
            spi_err_r  <= 1'b0;
        end else if (i_ce) begin
            if (wr_ok && i_bus.addr == prot_pkg::OFF_DIAG
                && i_bus.wdata[prot_pkg::DIAG_CHIPRST_POS]) begin
                chip_rst_r <= 1'b0;
            end
            if ((i_bus.wr | i_bus.rd) & ~frame_ok) begin
                spi_err_r <= 1'b1;
            end else if (wr_ok && i_bus.addr == prot_pkg::OFF_DIAG
                         && i_bus.wdata[prot_pkg::DIAG_SPIERR_POS]) begin
                spi_err_r <= 1'b0;
            end
        end
    end

    // restart failure and watchdog failure counters
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            v1_cnt_r <= '0;
            wd_cnt_r <= '0;
        end else if (i_ce) begin
            if (i_v1_restart_fail) begin
                v1_cnt_r <= sat_inc(v1_cnt_r);
            end else if (wr_ok && i_bus.addr == prot_pkg::OFF_COUNT) begin
                v1_cnt_r <= '0;
            end
            if (i_wd_fail) begin
                wd_cnt_r <= sat_inc(wd_cnt_r);
            end else if (i_wd_ok
                         || (wr_ok && i_bus.addr == prot_pkg::OFF_COUNT)) begin
                wd_cnt_r <= '0;
            end
        end
    end

    // read mux
    always_comb begin
        ovld_view = ovld_r & ~rec_mask;
        rd_val    = '0;
        unique case (i_bus.addr)
            prot_pkg::OFF_CTRL_OUT: rd_val[prot_pkg::NDRV-1:0] = ctrl_out_r;
            prot_pkg::OFF_CTRL4:    rd_val[3:0] = ctrl4_r;
            prot_pkg::OFF_OVLD:     rd_val[prot_pkg::NDRV-1:0] = ovld_view;
            prot_pkg::OFF_OPEN:     rd_val[prot_pkg::NDRV-1:0] = open_r;
            prot_pkg::OFF_SUPPLY: begin
                rd_val[prot_pkg::SUP_OV_POS] = ov_r;
                rd_val[prot_pkg::SUP_UV_POS] = uv_r;
            end
            prot_pkg::OFF_DIAG: begin
                rd_val[prot_pkg::DIAG_CHIPRST_POS] = chip_rst_r;
                rd_val[prot_pkg::DIAG_SPIERR_POS]  = spi_err_r;
                rd_val[prot_pkg::DIAG_THERM_POS +: 2] = therm_r;
            end
            prot_pkg::OFF_COUNT: begin
                rd_val[prot_pkg::CNT_W-1:0] = v1_cnt_r;
                rd_val[prot_pkg::COUNT_WD_POS +: prot_pkg::CNT_W] = wd_cnt_r;
            end
            prot_pkg::OFF_WAKE:     rd_val[prot_pkg::NDRV-1:0] = wake_r;
            default:                rd_val = '0;
        endcase
    end

    // registered read data, valid only the cycle after a read
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rdata <= '0;
        end else if (i_ce) begin
            o_rdata <= rd_ok ? rd_val : '0;
        end
    end

    // driver gates and thermal state output
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_drv_on      <= '0;
            o_therm_state <= 2'b00;
        end else if (i_ce) begin
            o_drv_on      <= ctrl_out_r & ~hard_off;
            o_therm_state <= therm_r;
        end
    end

endmodule : output_driver_protection_ctrl

// file: prot_pkg.sv
// constants and types for the output driver protection controller
package prot_pkg;

    // register bus geometry
    localparam int DW = 16;
    localparam int AW = 4;

    // driver indices: 0..3 small high-sides, 4 strong, 5..6 relays
    localparam int NDRV       = 7;
    localparam int NHS        = 5;
    localparam int THIRD_IDX  = 2;
    localparam int STRONG_IDX = 4;
    localparam int CNT_W      = 4;

    // serial frame length that a command must have
    localparam logic [5:0] FRAME_BITS = 6'h18;

    // register offsets
    localparam logic [AW-1:0] OFF_CTRL_OUT = 4'h0;
    localparam logic [AW-1:0] OFF_CTRL4    = 4'h1;
    localparam logic [AW-1:0] OFF_OVLD     = 4'h2;
    localparam logic [AW-1:0] OFF_OPEN     = 4'h3;
    localparam logic [AW-1:0] OFF_SUPPLY   = 4'h4;
    localparam logic [AW-1:0] OFF_DIAG     = 4'h5;
    localparam logic [AW-1:0] OFF_COUNT    = 4'h6;
    localparam logic [AW-1:0] OFF_WAKE     = 4'h7;

    // field positions
    localparam int CTRL4_VLOCK_POS    = 0;
    localparam int CTRL4_AUTOREC_POS  = 1;
    localparam int CTRL4_RELSF_POS    = 2;
    localparam int CTRL4_OUT3FSO_POS  = 3;
    localparam int SUP_OV_POS         = 0;
    localparam int SUP_UV_POS         = 1;
    localparam int DIAG_CHIPRST_POS   = 0;
    localparam int DIAG_SPIERR_POS    = 1;
    localparam int DIAG_THERM_POS     = 2;
    localparam int COUNT_WD_POS       = 4;

    // values after reset and the counter saturation limit
    localparam logic [NDRV-1:0] CTRL_OUT_RST = 7'h00;
    localparam logic [3:0]      CTRL4_RST    = 4'h0;
    localparam logic [CNT_W-1:0] CNT_MAX     = 4'hF;

    typedef enum logic [1:0] {
        TH_NORMAL,
        TH_WARN,
        TH_SD1,
        TH_SD2
    } therm_t;

    typedef struct packed {
        logic third_highside_output_fso;
        logic relay_sf_en;
        logic auto_rec;
        logic vlockout;
    } ctrl4_t;

    typedef struct packed {
        logic            wr;
        logic            rd;
        logic [AW-1:0]   addr;
        logic [DW-1:0]   wdata;
        logic [5:0]      bits;
    } bus_req_t;

    typedef struct packed {
        logic            ov;
        logic            uv;
        logic            tw;
        logic            thermal_shutdown_level_one;
        logic            thermal_shutdown_level_two;
        logic            failsafe;
        logic [NDRV-1:0] oc;
        logic [NHS-1:0]  ol;
    } fault_t;

endpackage : prot_pkg

// file: host_spi_model.sv
// host side model that issues register accesses as serial frames
`timescale 1ns/1ps
module host_spi_model (
    input  wire logic         i_clk,
    input  wire logic [15:0]  i_rdata,
    output prot_pkg::bus_req_t o_bus
);
    initial o_bus = '0;

    // full frames unless a short one is asked for
    task automatic wr(input logic [3:0] a, input logic [15:0] v,
                      input logic [5:0] b = prot_pkg::FRAME_BITS);
        @(posedge i_clk);
        o_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v, bits: b};
        @(posedge i_clk);
        o_bus.wr <= 1'b0;
    endtask : wr

    // read, also the read-and-clear of supply status
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge i_clk);
        o_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000,
                   bits: prot_pkg::FRAME_BITS};
        @(posedge i_clk);
        o_bus.rd <= 1'b0;
        #1 v = i_rdata;
    endtask : rd
endmodule : host_spi_model

// file: prot_ctrl_asserts.sv
// port assertions of the protection controller
`timescale 1ns/1ps
module prot_ctrl_asserts (
    input wire logic                      i_clk,
    input wire logic                      i_srst,
    input wire logic                      i_ce,
    input wire prot_pkg::bus_req_t        i_bus,
    input wire logic [prot_pkg::DW-1:0]   o_rdata,
    input wire prot_pkg::fault_t          i_fault_pin,
    input wire logic                      i_standby,
    input wire logic [prot_pkg::NDRV-1:0] o_drv_on,
    input wire logic [1:0]                o_therm_state
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence run2;
        i_ce [*2];
    endsequence
    sequence run3;
        i_ce [*3];
    endsequence
    sequence stby_exit;
        i_ce && $past(i_standby) && !i_standby;
    endsequence

    rdata_idle_a: assert property (i_ce && !(i_bus.rd &&
        i_bus.bits == prot_pkg::FRAME_BITS) |=> o_rdata == '0)
        else $error("read data not zero");
    reset_vals_a: assert property (disable iff (1'b0) i_srst && i_ce |=>
        o_drv_on == '0 && o_therm_state == 2'd0 && o_rdata == '0)
        else $error("reset values wrong");
    hs_ovld_a: assert property (i_ce && i_fault_pin.oc[0] ##1 run3
        |=> !o_drv_on[0]) else $error("overloaded driver on");
    rel_ovld_a: assert property (i_ce && i_fault_pin.oc[5] ##1 run3
        |=> !o_drv_on[5]) else $error("overloaded relay on");
    supply_off_a: assert property (i_ce && i_fault_pin.ov ##1 run2
        |=> o_drv_on[4:0] == 5'h00) else $error("high side on in fault");
    rel_fs_a: assert property (i_ce && i_fault_pin.failsafe ##1 run2
        |=> o_drv_on[6:5] == 2'b00) else $error("relay on in fail-safe");
    therm_off_a: assert property (i_ce && o_therm_state[1]
        |=> o_drv_on[1:0] == 2'b00) else $error("driver on when hot");
    stby_hold_a: assert property (i_ce && i_standby
        ##1 i_ce && i_standby
        |=> $stable(o_therm_state)) else $error("thermal state moved");
    stby_two_a: assert property (stby_exit ##0 o_therm_state == 2'd3
        ##1 i_ce |=> o_therm_state == 2'd2)
        else $error("level two not reduced");
    stby_same_a: assert property (stby_exit ##0 o_therm_state != 2'd3
        ##1 i_ce |=> $stable(o_therm_state))
        else $error("state not restored");
endmodule : prot_ctrl_asserts

bind output_driver_protection_ctrl prot_ctrl_asserts chk (
    .i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_bus(i_bus),
    .o_rdata(o_rdata), .i_fault_pin(i_fault_pin), .i_standby(i_standby),
    .o_drv_on(o_drv_on), .o_therm_state(o_therm_state));

// file: output_driver_protection_ctrl_tb.sv
// self-checking bench of the protection controller
`timescale 1ns/1ps
module output_driver_protection_ctrl_tb;
    logic               clk;
    logic               srst;
    prot_pkg::bus_req_t bus;
    logic [15:0]        rdata;
    prot_pkg::fault_t   flt;
    prot_pkg::fault_t   f;
    logic               stby;
    logic [6:0]         wake;
    logic               rfail;
    logic               wdf;
    logic               ce;
    logic               wdok;
    logic [6:0]         drv;
    logic [1:0]         th;
    logic [15:0]        d;
    int                 failures;
    int                 cmp_count;

    output_driver_protection_ctrl dut (.i_clk(clk), .i_srst(srst),
        .i_ce(ce), .i_bus(bus), .o_rdata(rdata), .i_fault_pin(flt),
        .i_standby(stby), .i_wake_evt(wake), .i_v1_restart_fail(rfail),
        .i_wd_fail(wdf), .i_wd_ok(wdok), .o_drv_on(drv),
        .o_therm_state(th));
    host_spi_model host (.i_clk(clk), .i_rdata(rdata), .o_bus(bus));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task cmp(input logic [15:0] g, input logic [15:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : cmp
    task rdc(input logic [3:0] a, input logic [15:0] e, input string m);
        host.rd(a, d);
        cmp(d, e, m);
    endtask : rdc
    task cd(input logic [6:0] e, input string m);
        cmp({9'h000, drv}, {9'h000, e}, m);
    endtask : cd
    task settle;
        repeat (6) @(posedge clk);
        #1;
    endtask : settle
    task apply;
        @(posedge clk) flt <= f;
        settle;
    endtask : apply
    task done(input string n);
        $display("test %s done", n);
    endtask : done
    task conclude;
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    initial begin
        #200000;
        failures++;
        conclude;
    end

    initial begin
        failures = 0; cmp_count = 0; f = '0; flt = '0; stby = 1'b0;
        wake = 7'h00; rfail = 1'b0; wdf = 1'b0; srst = 1'b1;
        ce = 1'b1;
        wdok = 1'b0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        settle;
        cd(7'h00, "reset drivers");
        rdc(4'h5, 16'h0001, "chip reset flag");
        host.wr(4'h0, 16'h007F);
        settle;
        cd(7'h7F, "all on");
        rdc(4'h8, 16'h0000, "unmapped");
        host.wr(4'h0, 16'h0000, 6'h17);
        settle;
        cd(7'h7F, "short frame ignored");
        rdc(4'h5, 16'h0003, "serial error flag");
        host.wr(4'h5, 16'h0003);
        done("bus");
        f.oc = 7'h21; apply; f.oc = 7'h00; apply;
        cd(7'h5E, "overload latched off");
        rdc(4'h2, 16'h0021, "overload status");
        host.wr(4'h2, 16'h0021);
        settle;
        cd(7'h7F, "overload cleared");
        f.ol = 5'h02; apply; f.ol = 5'h00; apply;
        cd(7'h7F, "open load keeps on");
        rdc(4'h3, 16'h0002, "open load status");
        host.wr(4'h3, 16'h0002);
        rdc(4'h3, 16'h0000, "open load cleared");
        done("load");
        host.wr(4'h1, 16'h0002);
        f.oc = 7'h10; apply; f.oc = 7'h00; apply;
        cd(7'h7F, "auto restart");
        rdc(4'h2, 16'h0000, "strong overload hidden");
        f.oc = 7'h10; apply;
        host.wr(4'h1, 16'h0000);
        settle;
        cd(7'h6F, "persistent overload off");
        host.wr(4'h1, 16'h0002);
        rdc(4'h2, 16'h0000, "latched strong hidden");
        host.wr(4'h1, 16'h0000);
        f.oc = 7'h00; apply;
        rdc(4'h2, 16'h0010, "strong overload shown");
        host.wr(4'h2, 16'h0010);
        settle;
        cd(7'h7F, "strong back on");
        done("recovery");
        f.ov = 1'b1; apply;
        cd(7'h60, "relays stay on");
        f.ov = 1'b0; apply;
        cd(7'h7F, "auto on without lockout");
        rdc(4'h4, 16'h0000, "status auto cleared");
        host.wr(4'h1, 16'h0005);
        f.uv = 1'b1; apply; f.uv = 1'b0; apply;
        cd(7'h00, "lockout holds off");
        rdc(4'h4, 16'h0002, "undervoltage status");
        settle;
        cd(7'h7F, "on after read clear");
        done("supply");
        host.wr(4'h1, 16'h0008);
        f.tw = 1'b1; f.thermal_shutdown_level_one = 1'b1; apply;
        cmp({14'h0000, th}, 16'h0002, "level one");
        cd(7'h04, "hot drivers off");
        @(posedge clk) stby <= 1'b1;
        settle;
        @(posedge clk) stby <= 1'b0;
        settle;
        cmp({14'h0000, th}, 16'h0002, "level one kept");
        f.thermal_shutdown_level_two = 1'b1; apply;
        cmp({14'h0000, th}, 16'h0003, "level two");
        @(posedge clk) stby <= 1'b1;
        f = '0; apply;
        cmp({14'h0000, th}, 16'h0003, "frozen in standby");
        @(posedge clk) stby <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        cmp({14'h0000, th}, 16'h0002, "back as level one");
        settle;
        host.wr(4'h2, 16'h007F);
        settle;
        cd(7'h7F, "thermal latch cleared");
        done("thermal");
        host.wr(4'h1, 16'h0000);
        f.failsafe = 1'b1; apply;
        cd(7'h04, "fail-safe off");
        rdc(4'h0, 16'h0004, "controls defaulted");
        f = '0; apply;
        done("failsafe");
        @(posedge clk) ce <= 1'b0;
        host.wr(4'h0, 16'h0000);
        @(posedge clk) ce <= 1'b1;
        settle;
        cd(7'h04, "write ignored while frozen");
        done("enable");
        for (int i = 0; i < 3; i++) begin
            @(posedge clk) begin
                wake <= 7'h7F;
                rfail <= 1'b1;
                wdf <= (i < 2);
            end
            @(posedge clk) begin
                wake <= 7'h00;
                rfail <= 1'b0;
                wdf <= 1'b0;
            end
        end
        settle;
        rdc(4'h7, 16'h007F, "wake sources");
        rdc(4'h6, 16'h0023, "fail counters");
        @(posedge clk) wdok <= 1'b1;
        @(posedge clk) wdok <= 1'b0;
        settle;
        rdc(4'h6, 16'h0003, "watchdog count reset");
        done("diag");
        @(posedge clk) srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        settle;
        cd(7'h00, "drivers after reset");
        rdc(4'h5, 16'h0001, "chip flag after reset");
        done("reset");
        conclude;
    end
endmodule : output_driver_protection_ctrl_tb
